// *** design/pdi_regs.vh ***
`ifndef PDI_REGS_VH
`define PDI_REGS_VH

// Register addresses
`define PDI_ADDR_ERR_STAT 16'h1A83
`define PDI_ADDR_PM_STAT 16'h1A84
`define PDI_ADDR_SOP_STAT 16'h1A85
`define PDI_ADDR_ERR_EN 16'h1A88
`define PDI_ADDR_PM_EN 16'h1A89
`define PDI_ADDR_SOP_EN 16'h1A90
`define PDI_ADDR_MODE 16'h1A91
`define PDI_ADDR_PKT_STAT 16'h1A92
`define PDI_ADDR_BAD_CNT 16'h1A93
`define PDI_ADDR_DUP_CNT 16'h1A94
`define PDI_ADDR_BAD_LIM 16'h1A95
`define PDI_ADDR_DUP_LIM 16'h1A96

// Error status bit positions
`define PDI_ERR_DROP 0
`define PDI_ERR_PCOL 1
`define PDI_ERR_OVR 2
`define PDI_ERR_BAD 3
`define PDI_ERR_DBG 7

// Power status and enable bit positions
`define PDI_PM_WAKE 0
`define PDI_PM_WU 2
`define PDI_PM_STOP 3

// Packet status bit positions
`define PDI_PKT_CRC 0
`define PDI_PKT_OVERSIZE 3
`define PDI_PKT_FULL 4
`define PDI_PKT_SYM 5
`define PDI_PKT_ODD 6

// Mode bit positions
`define PDI_MODE_RETRY 0
`define PDI_MODE_RESP 1

// Implemented bits and reset values
`define PDI_ERR_MASK 8'h8F
`define PDI_PM_STAT_MASK 8'h01
`define PDI_PM_EN_MASK 8'h0D
`define PDI_SOP_MASK 8'h1F
`define PDI_PKT_MASK 8'h79
`define PDI_MODE_MASK 8'h03
`define PDI_STAT_RST 8'h00
`define PDI_EN_RST 8'h00
`define PDI_LIM_RST 8'hFF

`endif

// *** design/pdi_sync2.v ***
module pdi_sync2 (
  input wire sys_clk_i,
  input wire rst_i,
  input wire async_i,
  output reg sync_o
);

  reg meta;

  // Two stages; only the second stage is read outside
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule

// *** design/pdi_event_counter.v ***
module pdi_event_counter #(
  parameter WIDTH = 8
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire inc_i,
  input wire clr_i,
  input wire [WIDTH-1:0] limit_i,
  output reg [WIDTH-1:0] count_o,
  output wire at_limit_o
);

  // Level stays high until software clears the count
  assign at_limit_o = (count_o == limit_i);

  // Saturates at the limit so the level cannot wrap away
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_o <= {WIDTH{1'b0}};
    end else if (clr_i) begin
      count_o <= {WIDTH{1'b0}};
    end else if (inc_i && !at_limit_o) begin
      count_o <= count_o + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule

// *** design/pdi_rx_status.v ***
// Operation
// RQ1: Flags set by hardware, cleared by writing one
// RQ2: Error interrupt needs matching error enable bit
// RQ3: Debug flag set when either counter limits
// RQ4: Debug flag re-sets while limit condition holds
// RQ5: Software reads both counters after debug event
// RQ6: Corrupt packet sets flag and status bits
// RQ7: No buffer space: overflow, full bit, discard
// RQ8: Retry mode mismatch while awaiting acknowledge
// RQ9: Mismatch stores message, sets receive complete
// RQ10: Mismatch abandons retry, sets transmit abort
// RQ11: Discard flag on duplicate or acknowledge drop
// RQ12: Wake flag set asynchronously by line activity
// RQ13: Software enables wake only before clock stop
// RQ14: Cleared wake enable blocks flag setting
// RQ15: Wake flag ignores clock halt/wakeup enables
// RQ16: Wake interrupt needs power interrupt enable
// RQ17: Frame start flags ignore receive control
// RQ18: Frame start flags bits 4:0, rest reserved
// RQ19: Frame start flags drive own interrupt
// RQ20: Frame start interrupt needs matching enable
// RQ21: All interrupt enables reset to zero
// RQ22: Enables gate interrupts, flags still record
// RQ23: Interrupt outputs are OR of qualified flags
//
// The address-and-strobe port was left to the implementer.
`include "pdi_regs.vh"

module pdi_rx_status #(
  parameter CNT_W = 8
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [15:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  input wire line_rx_i,
  input wire bad_crc_i,
  input wire sym_err_i,
  input wire oversize_i,
  input wire odd_nibble_i,
  input wire pkt_start_i,
  input wire buf_full_i,
  input wire msg_done_i,
  input wire msg_goodcrc_i,
  input wire msg_ping_i,
  input wire msg_dup_i,
  input wire await_goodcrc_i,
  input wire sop_seen_i,
  input wire [2:0] sop_kind_i,
  output reg err_irq_o,
  output reg pm_irq_o,
  output reg sop_irq_o,
  output reg rx_discard_o,
  output reg msg_drop_o,
  output reg queue_store_o,
  output reg rx_done_set_o,
  output reg retry_abort_o,
  output reg tx_abort_set_o,
  output reg clk_stop_en_o,
  output reg wakeup_en_o
);

  // Status, enable and control registers
  reg [7:0] err_stat;
  reg [7:0] sop_stat;
  reg [7:0] pkt_stat;
  reg [7:0] err_en;
  reg [7:0] pm_en;
  reg [7:0] sop_en;
  reg [7:0] mode;
  reg [CNT_W-1:0] bad_lim;
  reg [CNT_W-1:0] dup_lim;

  // Asynchronous wake capture and its synchronised copy
  reg wake_catch;
  wire wake_sync;
  wire wake_arm;

  // Counter wiring
  wire [CNT_W-1:0] bad_cnt;
  wire [CNT_W-1:0] dup_cnt;
  wire bad_at_lim;
  wire dup_at_lim;

  // Decoded events
  wire retry_mode;
  wire resp_mode;
  wire corrupt;
  wire overflow;
  wire mismatch;
  wire ack_drop;
  wire dup_drop;
  wire [7:0] sop_set;
  wire [7:0] err_set;
  wire [7:0] pkt_set;

  // Write decode
  wire wr_err;
  wire wr_pm;
  wire wr_sop;
  wire wr_pkt;
  wire wr_bad_cnt;
  wire wr_dup_cnt;

  // Next values
  wire [7:0] next_err_stat;
  wire [7:0] next_sop_stat;
  wire [7:0] next_pkt_stat;
  reg [7:0] next_rdata;

  // Write-one-to-clear update; a set in the clear cycle wins
  function [7:0] pdi_w1c;
    input [7:0] cur;
    input [7:0] set;
    input [7:0] clr;
    input [7:0] mask;
    begin
      pdi_w1c = ((cur & ~clr) | set) & mask;
    end
  endfunction

  // Address hit for a write strobe
  function pdi_hit;
    input [15:0] addr;
    input [15:0] target;
    begin
      pdi_hit = reg_wr_i && (addr == target);
    end
  endfunction

  assign wr_err = pdi_hit(reg_addr_i, `PDI_ADDR_ERR_STAT);
  assign wr_pm = pdi_hit(reg_addr_i, `PDI_ADDR_PM_STAT);
  assign wr_sop = pdi_hit(reg_addr_i, `PDI_ADDR_SOP_STAT);
  assign wr_pkt = pdi_hit(reg_addr_i, `PDI_ADDR_PKT_STAT);
  assign wr_bad_cnt = pdi_hit(reg_addr_i, `PDI_ADDR_BAD_CNT);
  assign wr_dup_cnt = pdi_hit(reg_addr_i, `PDI_ADDR_DUP_CNT);

  // Mode selects
  assign retry_mode = mode[`PDI_MODE_RETRY];
  assign resp_mode = mode[`PDI_MODE_RESP];

  // Receive error decode
  assign corrupt = bad_crc_i | sym_err_i | oversize_i | odd_nibble_i; // [RQ6]
  assign overflow = pkt_start_i & buf_full_i; // [RQ7]
  assign mismatch = retry_mode & await_goodcrc_i & msg_done_i
    & ~msg_goodcrc_i & ~msg_ping_i; // [RQ8]
  assign ack_drop = retry_mode & await_goodcrc_i & msg_done_i & msg_goodcrc_i; // [RQ11]
  assign dup_drop = resp_mode & msg_done_i & msg_dup_i; // [RQ11]

  // Error flag sources; debug bit follows the counter levels
  assign err_set = {bad_at_lim | dup_at_lim, 3'b000, corrupt, overflow,
    mismatch, ack_drop | dup_drop}; // [RQ3] [RQ4]

  // Packet status sources
  assign pkt_set = {1'b0, odd_nibble_i, sym_err_i, overflow,
    oversize_i, 2'b00, bad_crc_i}; // [RQ6] [RQ7]

  // Frame start kind; codes above 4 are not valid kinds
  assign sop_set = (sop_seen_i && sop_kind_i < 3'd5) ? (8'h01 << sop_kind_i) : 8'h00; // [RQ17]

  assign next_err_stat = pdi_w1c(err_stat, err_set,
    wr_err ? reg_wdata_i : 8'h00, `PDI_ERR_MASK); // [RQ1] [RQ22]
  assign next_sop_stat = pdi_w1c(sop_stat, sop_set,
    wr_sop ? reg_wdata_i : 8'h00, `PDI_SOP_MASK); // [RQ1] [RQ18]
  assign next_pkt_stat = pdi_w1c(pkt_stat, pkt_set,
    wr_pkt ? reg_wdata_i : 8'h00, `PDI_PKT_MASK);

  // Status registers
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      err_stat <= `PDI_STAT_RST;
      sop_stat <= `PDI_STAT_RST;
      pkt_stat <= `PDI_STAT_RST;
    end else begin
      err_stat <= next_err_stat;
      sop_stat <= next_sop_stat;
      pkt_stat <= next_pkt_stat;
    end
  end

  // Enable and control registers; enables and mode clear at reset, limits reset to all ones
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      err_en <= `PDI_EN_RST; // [RQ21]
      pm_en <= `PDI_EN_RST; // [RQ21]
      sop_en <= `PDI_EN_RST; // [RQ21]
      mode <= `PDI_STAT_RST;
      bad_lim <= `PDI_LIM_RST;
      dup_lim <= `PDI_LIM_RST;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `PDI_ADDR_ERR_EN: begin
          err_en <= reg_wdata_i & `PDI_ERR_MASK;
        end
        `PDI_ADDR_PM_EN: begin
          pm_en <= reg_wdata_i & `PDI_PM_EN_MASK;
        end
        `PDI_ADDR_SOP_EN: begin
          sop_en <= reg_wdata_i & `PDI_SOP_MASK;
        end
        `PDI_ADDR_MODE: begin
          mode <= reg_wdata_i & `PDI_MODE_MASK;
        end
        `PDI_ADDR_BAD_LIM: begin
          bad_lim <= reg_wdata_i[CNT_W-1:0];
        end
        `PDI_ADDR_DUP_LIM: begin
          dup_lim <= reg_wdata_i[CNT_W-1:0];
        end
        default: begin
          mode <= mode;
        end
      endcase
    end
  end

  // Link quality counters; any write to a count clears it
  pdi_event_counter #(
    .WIDTH(CNT_W)
  ) u_bad_cnt (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .inc_i(bad_crc_i),
    .clr_i(wr_bad_cnt),
    .limit_i(bad_lim),
    .count_o(bad_cnt),
    .at_limit_o(bad_at_lim)
  );

  pdi_event_counter #(
    .WIDTH(CNT_W)
  ) u_dup_cnt (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .inc_i(dup_drop),
    .clr_i(wr_dup_cnt),
    .limit_i(dup_lim),
    .count_o(dup_cnt),
    .at_limit_o(dup_at_lim)
  );

  // Wake arming ignores the clock halt and wakeup bits
  assign wake_arm = line_rx_i & pm_en[`PDI_PM_WAKE]; // [RQ14] [RQ15]

  // Set without a clock so activity is caught while clocks are stopped;
  // a clear cannot beat an active set since the set is asynchronous
  always @(posedge sys_clk_i or posedge rst_i or posedge wake_arm) begin
    if (rst_i) begin
      wake_catch <= 1'b0;
    end else if (wake_arm) begin
      wake_catch <= 1'b1; // [RQ12]
    end else if (wr_pm && reg_wdata_i[`PDI_PM_WAKE]) begin
      wake_catch <= 1'b0; // [RQ1]
    end
  end

  // Catch flop leaves its domain only through two stages
  pdi_sync2 u_wake_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .async_i(wake_catch),
    .sync_o(wake_sync)
  );

  // Interrupt outputs, each the OR of its qualified flags
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      err_irq_o <= 1'b0;
      pm_irq_o <= 1'b0;
      sop_irq_o <= 1'b0;
    end else begin
      err_irq_o <= |(err_stat & err_en); // [RQ2] [RQ23]
      pm_irq_o <= wake_sync & pm_en[`PDI_PM_WAKE]; // [RQ16] [RQ23]
      sop_irq_o <= |(sop_stat & sop_en); // [RQ19] [RQ20]
    end
  end

  // Side effects towards the receive and transmit engines
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_discard_o <= 1'b0;
      msg_drop_o <= 1'b0;
      queue_store_o <= 1'b0;
      rx_done_set_o <= 1'b0;
      retry_abort_o <= 1'b0;
      tx_abort_set_o <= 1'b0;
    end else begin
      rx_discard_o <= overflow; // [RQ7]
      msg_drop_o <= ack_drop | dup_drop; // [RQ11]
      queue_store_o <= mismatch; // [RQ9]
      rx_done_set_o <= mismatch; // [RQ9]
      retry_abort_o <= mismatch; // [RQ10]
      tx_abort_set_o <= mismatch; // [RQ10]
    end
  end

  // Clock request enables pass to the clock controller
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      clk_stop_en_o <= 1'b0;
      wakeup_en_o <= 1'b0;
    end else begin
      clk_stop_en_o <= pm_en[`PDI_PM_STOP];
      wakeup_en_o <= pm_en[`PDI_PM_WU];
    end
  end

  // Read mux; reserved bits and unmapped addresses read zero
  always @* begin
    next_rdata = 8'h00;
    case (reg_addr_i)
      `PDI_ADDR_ERR_STAT: begin
        next_rdata = err_stat;
      end
      `PDI_ADDR_PM_STAT: begin
        next_rdata = {7'h00, wake_sync};
      end
      `PDI_ADDR_SOP_STAT: begin
        next_rdata = sop_stat; // [RQ18]
      end
      `PDI_ADDR_ERR_EN: begin
        next_rdata = err_en;
      end
      `PDI_ADDR_PM_EN: begin
        next_rdata = pm_en;
      end
      `PDI_ADDR_SOP_EN: begin
        next_rdata = sop_en;
      end
      `PDI_ADDR_MODE: begin
        next_rdata = mode;
      end
      `PDI_ADDR_PKT_STAT: begin
        next_rdata = pkt_stat;
      end
      `PDI_ADDR_BAD_CNT: begin
        next_rdata = bad_cnt; // [RQ5]
      end
      `PDI_ADDR_DUP_CNT: begin
        next_rdata = dup_cnt; // [RQ5]
      end
      `PDI_ADDR_BAD_LIM: begin
        next_rdata = bad_lim;
      end
      `PDI_ADDR_DUP_LIM: begin
        next_rdata = dup_lim;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

endmodule

// *** tb/pdi_rx_status_asserts.sv ***
module pdi_rx_status_asserts (
  input wire sys_clk_i, rst_i, reg_wr_i, reg_rd_i, pkt_start_i, buf_full_i, msg_done_i,
  input wire msg_goodcrc_i, msg_ping_i, msg_dup_i, await_goodcrc_i,
  input wire [7:0] reg_rdata_o,
  input wire err_irq_o, pm_irq_o, sop_irq_o, rx_discard_o, msg_drop_o,
  input wire queue_store_o, rx_done_set_o, retry_abort_o, tx_abort_set_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Single clock domain, so one default clocking and reset
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Mismatch side pulses travel together
  a_mismatch_pulses_together: assert property (queue_store_o |-> rx_done_set_o && retry_abort_o && tx_abort_set_o)
    else $error("mismatch side pulses not together");
  a_mismatch_has_cause: assert property (queue_store_o |-> $past(msg_done_i && await_goodcrc_i && !msg_goodcrc_i && !msg_ping_i))
    else $error("mismatch pulse without cause");
  a_overflow_discards: assert property (pkt_start_i && buf_full_i |=> rx_discard_o)
    else $error("overflow packet not discarded");
  a_discard_has_cause: assert property (rx_discard_o |-> $past(pkt_start_i && buf_full_i))
    else $error("discard without full buffer");
  a_drop_has_cause: assert property (msg_drop_o |-> $past(msg_done_i && (msg_goodcrc_i || msg_dup_i)))
    else $error("drop pulse without cause");
  a_irq_quiet_release: assert property ($fell(rst_i) |-> !err_irq_o && !pm_irq_o && !sop_irq_o)
    else $error("interrupt high after reset");
  // Irqs only fall two edges after a write: flag clear, then irq flop
  a_err_irq_cleared: assert property ($fell(err_irq_o) |-> $past(reg_wr_i, 2) || $past(reg_wr_i))
    else $error("error irq fell without write");
  a_sop_irq_cleared: assert property ($fell(sop_irq_o) |-> $past(reg_wr_i, 2) || $past(reg_wr_i))
    else $error("frame start irq fell without write");
  a_rdata_idle_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside read cycle");
  c_err_irq: cover property ($rose(err_irq_o));
  c_pm_irq: cover property ($rose(pm_irq_o));
  c_sop_irq: cover property ($rose(sop_irq_o));
endmodule

bind pdi_rx_status pdi_rx_status_asserts u_chk (.sys_clk_i, .rst_i, .reg_wr_i, .reg_rd_i, .pkt_start_i,
  .buf_full_i, .msg_done_i, .msg_goodcrc_i, .msg_ping_i, .msg_dup_i, .await_goodcrc_i, .reg_rdata_o,
  .err_irq_o, .pm_irq_o, .sop_irq_o, .rx_discard_o, .msg_drop_o, .queue_store_o, .rx_done_set_o,
  .retry_abort_o, .tx_abort_set_o);

// *** tb/pdi_far_end.sv ***
module pdi_far_end (
  input wire sys_clk_i,
  input wire go_i,
  input wire [3:0] kind_i,
  output logic line_rx_i, bad_crc_i, sym_err_i, oversize_i, odd_nibble_i, pkt_start_i, buf_full_i,
  output logic msg_done_i, msg_goodcrc_i, msg_ping_i, msg_dup_i, await_goodcrc_i, sop_seen_i,
  output logic [2:0] sop_kind_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // One event per request; lines fall idle after, kind toggles so no stale value lingers
  always @(posedge sys_clk_i) begin
    {line_rx_i, bad_crc_i, sym_err_i, oversize_i, odd_nibble_i, pkt_start_i, buf_full_i} <= 7'h00;
    {msg_done_i, msg_goodcrc_i, msg_ping_i, msg_dup_i, await_goodcrc_i, sop_seen_i} <= 6'h00;
    sop_kind_i <= ~sop_kind_i;
    if (go_i) begin
      case (kind_i)
        4'h0: bad_crc_i <= 1'b1;
        4'h1: sym_err_i <= 1'b1;
        4'h2: oversize_i <= 1'b1;
        4'h3: odd_nibble_i <= 1'b1;
        4'h4: {pkt_start_i, buf_full_i} <= 2'h3;
        4'h5: {msg_done_i, await_goodcrc_i} <= 2'h3;
        4'h6: {msg_done_i, await_goodcrc_i, msg_goodcrc_i} <= 3'h7;
        4'h7: {msg_done_i, await_goodcrc_i, msg_ping_i} <= 3'h7;
        4'hE: line_rx_i <= 1'b1;
        4'hF: {msg_done_i, msg_dup_i} <= 2'h3;
        default: begin
          sop_seen_i <= 1'b1;
          sop_kind_i <= kind_i[2:0];
        end
      endcase
    end
  end
endmodule

// *** tb/pdi_rx_status_test.sv ***
`include "pdi_regs.vh"
module pdi_rx_status_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, go = 1'b0;
  logic [15:0] reg_addr_i = 16'h0000, a;
  logic [7:0] reg_wdata_i = 8'h00, d;
  logic [3:0] kind = 4'h0;
  logic [23:0] r;
  wire line_rx_i, bad_crc_i, sym_err_i, oversize_i, odd_nibble_i, pkt_start_i, buf_full_i, msg_done_i;
  wire msg_goodcrc_i, msg_ping_i, msg_dup_i, await_goodcrc_i, sop_seen_i;
  wire [2:0] sop_kind_i;
  wire [7:0] reg_rdata_o;
  wire err_irq_o, pm_irq_o, sop_irq_o, rx_discard_o, msg_drop_o, queue_store_o, rx_done_set_o;
  wire retry_abort_o, tx_abort_set_o, clk_stop_en_o, wakeup_en_o;
  int num_errors = 0, comparisons = 0, cycles = 0;
  // Side pulses seen since the last request: mismatch group, drop, discard
  logic [2:0] side = 3'h0;
  // Row: event kind, side pulses, frame start register flag, status value, packet status value
  logic [23:0] rows [15] = '{24'h000801, 24'h100820, 24'h200808, 24'h300840, 24'h420410,
    24'h580200, 24'h640100, 24'h700000, 24'h810100, 24'h910200, 24'hA10400, 24'hB10800,
    24'hC11000, 24'hD10000, 24'hF40100};

  pdi_rx_status DUT (.sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .line_rx_i, .bad_crc_i, .sym_err_i, .oversize_i, .odd_nibble_i, .pkt_start_i, .buf_full_i,
    .msg_done_i, .msg_goodcrc_i, .msg_ping_i, .msg_dup_i, .await_goodcrc_i, .sop_seen_i, .sop_kind_i,
    .err_irq_o, .pm_irq_o, .sop_irq_o, .rx_discard_o, .msg_drop_o, .queue_store_o, .rx_done_set_o,
    .retry_abort_o, .tx_abort_set_o, .clk_stop_en_o, .wakeup_en_o);
  pdi_far_end u_far (.sys_clk_i, .go_i(go), .kind_i(kind), .line_rx_i, .bad_crc_i, .sym_err_i,
    .oversize_i, .odd_nibble_i, .pkt_start_i, .buf_full_i, .msg_done_i, .msg_goodcrc_i, .msg_ping_i,
    .msg_dup_i, .await_goodcrc_i, .sop_seen_i, .sop_kind_i);

  initial begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  // Pulses stand one cycle only, so they are collected; a new request starts afresh
  always @(posedge sys_clk_i) begin
    if (go)
      side <= 3'h0;
    else
      side <= side | {queue_store_o & rx_done_set_o & retry_abort_o & tx_abort_set_o, msg_drop_o, rx_discard_o};
  end

  task automatic tally_and_finish();
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard, far above the roughly 390 cycles the run needs
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [15:0] ad, input logic [7:0] da);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= ad;
    reg_wdata_i <= da;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] ad, output logic [7:0] da);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= ad;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge sys_clk_i);
    da = reg_rdata_o;
  endtask

  task automatic fire(input logic [3:0] k, input int w);
    @(posedge sys_clk_i);
    go <= 1'b1;
    kind <= k;
    @(posedge sys_clk_i);
    go <= 1'b0;
    repeat (w) @(posedge sys_clk_i);
  endtask

  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(`PDI_ADDR_ERR_STAT, d);
    chk(d, 8'h00);
    rd(`PDI_ADDR_PM_EN, d);
    chk(d, 8'h00);
    chk(8'({err_irq_o, pm_irq_o, sop_irq_o}), 8'h00);
    wr(`PDI_ADDR_MODE, 8'h03);
    for (int i = 0; i < 15; i++) begin
      r = rows[i];
      a = r[16] ? `PDI_ADDR_SOP_STAT : `PDI_ADDR_ERR_STAT;
      fire(r[23:20], 2);
      rd(a, d);
      chk(d, r[15:8]);
      chk(8'(side), 8'(r[19:17]));
      rd(`PDI_ADDR_PKT_STAT, d);
      chk(d, r[7:0]);
      wr(a, 8'hFF);
      wr(`PDI_ADDR_PKT_STAT, 8'hFF);
      rd(a, d);
      chk(d, 8'h00);
    end
    rd(16'h1A8F, d);
    chk(d, 8'h00);
    // Outside retry and response modes neither mismatch nor drop is flagged
    wr(`PDI_ADDR_MODE, 8'h00);
    fire(4'h5, 2);
    rd(`PDI_ADDR_ERR_STAT, d);
    chk(d, 8'h00);
    chk(8'(side), 8'h00);
    fire(4'hF, 2);
    rd(`PDI_ADDR_ERR_STAT, d);
    chk(d, 8'h00);
    chk(8'(side), 8'h00);
    // Enable gates only the irq, the flag records anyway
    fire(4'h0, 3);
    chk(8'(err_irq_o), 8'h00);
    wr(`PDI_ADDR_ERR_EN, 8'h08);
    repeat (3) @(posedge sys_clk_i);
    chk(8'(err_irq_o), 8'h01);
    wr(`PDI_ADDR_ERR_STAT, 8'h08);
    repeat (3) @(posedge sys_clk_i);
    chk(8'(err_irq_o), 8'h00);
    wr(`PDI_ADDR_SOP_EN, 8'h02);
    fire(4'h8, 3);
    chk(8'(sop_irq_o), 8'h00);
    fire(4'h9, 3);
    chk(8'({err_irq_o, sop_irq_o}), 8'h01);
    wr(`PDI_ADDR_SOP_STAT, 8'hFF);
    // Wake flag blocked while its enable is clear, halt bits irrelevant
    wr(`PDI_ADDR_PM_EN, 8'h0C);
    fire(4'hE, 4);
    rd(`PDI_ADDR_PM_STAT, d);
    chk(d, 8'h00);
    chk(8'({clk_stop_en_o, wakeup_en_o}), 8'h03);
    // Wake enabled alone with the clock stop bit clear, then disabled again
    wr(`PDI_ADDR_PM_EN, 8'h01);
    fire(4'hE, 4);
    rd(`PDI_ADDR_PM_STAT, d);
    chk(d, 8'h01);
    chk(8'(pm_irq_o), 8'h01);
    wr(`PDI_ADDR_PM_STAT, 8'h01);
    wr(`PDI_ADDR_PM_EN, 8'h00);
    rd(`PDI_ADDR_PM_STAT, d);
    chk(d, 8'h00);
    // Debug flag keeps coming back until the counter is cleared
    wr(`PDI_ADDR_BAD_CNT, 8'h00);
    wr(`PDI_ADDR_BAD_LIM, 8'h01);
    fire(4'h0, 3);
    rd(`PDI_ADDR_ERR_STAT, d);
    chk(d, 8'h88);
    wr(`PDI_ADDR_ERR_STAT, 8'h80);
    rd(`PDI_ADDR_ERR_STAT, d);
    chk(d, 8'h88);
    rd(`PDI_ADDR_BAD_CNT, d);
    chk(d, 8'h01);
    rd(`PDI_ADDR_DUP_CNT, d);
    chk(d, 8'h01);
    wr(`PDI_ADDR_BAD_CNT, 8'h00);
    wr(`PDI_ADDR_ERR_STAT, 8'hFF);
    rd(`PDI_ADDR_ERR_STAT, d);
    chk(d, 8'h00);
    // Reset in mid-run drops enables written earlier back to zero
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(`PDI_ADDR_ERR_EN, d);
    chk(d, 8'h00);
    rd(`PDI_ADDR_SOP_EN, d);
    chk(d, 8'h00);
    tally_and_finish();
  end
endmodule
